// ---- scs_frame_detector.sv ----
// Purpose: flags a word-select period longer than the limit
// Assumes: word_select already synchronised by the caller
// Notes:   counts ref_clk cycles between rising edges
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_frame_detector
   import scs_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic word_select,
   scs_rate_if.det   rate
);
   logic        ws_prev;
   logic [11:0] period;

   // period counter saturates so a dead word select reads as too slow
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ws_prev <= 1'b0;
         period <= 12'h000;
         rate.frame_rate_low <= 1'b0;
      end else begin
         ws_prev <= word_select;
         if (!rate.detector_on) begin // [RULE_06]
            period <= 12'h000;
            rate.frame_rate_low <= 1'b0;
         end else if (word_select && !ws_prev) begin
            period <= 12'h000;
            rate.frame_rate_low <= 1'b0;
         end else if (period >= rate.limit_cycles) begin // [RULE_07]
            rate.frame_rate_low <= 1'b1;
         end else begin
            period <= period + 12'h001;
         end
      end
   end

   // flag must rise one cycle after the count reaches the limit, not before
   low_after_limit_a: assert property ( // [RULE_07]
      @(posedge ref_clk) disable iff (!resetn)
      (rate.detector_on && !(word_select && !ws_prev)
      && period >= rate.limit_cycles) |=> rate.frame_rate_low)
      else $error("detector missed the lower frequency limit");
   low_not_early_a: assert property ( // [RULE_07]
      @(posedge ref_clk) disable iff (!resetn)
      (rate.detector_on && period < rate.limit_cycles
      && !rate.frame_rate_low) |=> !rate.frame_rate_low)
      else $error("detector flag raised before the limit");
   det_off_clear_a: assert property ( // [RULE_06]
      @(posedge ref_clk) disable iff (!resetn)
      !rate.detector_on |=> !rate.frame_rate_low)
      else $error("detector flag set while disabled");
endmodule

// ---- scs_params.svh ----
// Purpose: constants for the system clock and mode settings register
// Assumes: 16-bit register written as one word at offset 0x00
// Notes:   rule summary follows
// Function
// [RULE_01] Bit 13 powers the oscillator and PLL and resets to one.
// [RULE_02] Bits 12 to 8 pick the sampling rate and a 256x or 384x clock.
// [RULE_03] Crystal-derived bit clocks run at 64fs for 256x, 48fs for 384x.
// [RULE_04] Codes 0-11 cover 16/32/64 and 22.05/44.1/88.2 kHz, even is 256x.
// [RULE_05] Bits 7 to 4 hold the application mode, defaulting to mode 2.
// [RULE_06] Bit 3 enables the frame rate detector and resets to one.
// [RULE_07] Bit 2 picks a detector limit of 4095 (0) or 2047 (1) cycles.
// [RULE_08] Bits 1:0 pick PLL 256fs, PLL 384fs or the crystal clock.
// [RULE_09] PLL-derived bit clocks run at 64fs for select 00 or 10, else 48fs. Code treats select 10 as crystal, with the ratio set by divider bit 0.
// [RULE_10] Host keeps bit 15 at zero; bit 14 is reserved.
// [RULE_11] Each mode field value 0 to 15 selects the mode of that number.
// [RULE_12] With power off, every derived clock stops toggling.
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
`define SCS_REG_OFFSET   8'h00
`define SCS_RESET_VALUE  16'h282a
`define SCS_BIT_EVAL     15
`define SCS_BIT_POWER    13
`define SCS_DIV_HI       12
`define SCS_DIV_LO       8
`define SCS_MODE_HI      7
`define SCS_MODE_LO      4
`define SCS_BIT_DET_EN   3
`define SCS_BIT_DET_LIM  2
`define SCS_SEL_HI       1
`define SCS_SEL_LO       0
`define SCS_DIV_MAX      5'h0b
`define SCS_LIMIT_LOW    12'hfff
`define SCS_LIMIT_HIGH   12'h7ff
`define SCS_BCK_256      7'h40
`define SCS_BCK_384      7'h30
`define SCS_WRITE_MASK   16'hbfff
`define SCS_MODE_RESET   4'h2
`define SCS_RATE_RESET   3'h4
`endif

// ---- scs_pkg.sv ----
// Purpose: shared types for the system clock settings block
// Assumes: nothing beyond the constants header
// Notes:   source select encodes bits 1:0
package scs_pkg;
   typedef enum logic [1:0] {
      SCS_PLL_256,
      SCS_PLL_384,
      SCS_XTAL_A,
      SCS_XTAL_B
   } scs_src_t;
endpackage

// ---- scs_rate_if.sv ----
// Purpose: carries the decoded detector enable and cycle limit to the detector
// Assumes: one clock domain
// Notes:   plain levels, no handshake
`timescale 1ns/1ps
interface scs_rate_if;
   logic        detector_on;
   logic [11:0] limit_cycles;
   logic        frame_rate_low;
   modport ctrl (output detector_on, output limit_cycles,
                 input frame_rate_low);
   modport det  (input detector_on, input limit_cycles,
                 output frame_rate_low);
endinterface

// ---- scs_system_clock.sv ----
// Purpose: system clock and mode register with derived clock enables
// Assumes: register written by a word strobe from the control bus decoder
// Notes:   clocks are modelled as one-cycle enables of ref_clk
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_system_clock
   import scs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_write,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        pll_ref_tick,
   input  wire logic        xtal_tick,
   input  wire logic        word_select_pin,
   output logic      [3:0]  app_mode,
   output logic      [2:0]  sample_rate_code,
   output logic             sysclk_is_384,
   output logic             osc_pll_power_on,
   output logic             clock_out_en,
   output logic             output_bit_clock_en,
   output logic             input_bit_clock_en,
   output logic      [6:0]  bit_clock_ratio,
   output logic             frame_rate_low,
   output logic             vendor_eval_bit
);
   logic [15:0] settings;
   logic        ws_s1, ws_s2;
   logic [4:0]  crystal_divider_sel;
   logic [1:0]  clock_output_source_sel;
   logic        from_xtal, ratio_384, src_tick;
   scs_rate_if  rate ();
   scs_src_t    source_kind;

   // register write; bit 14 is forced to zero since it is reserved, so
   // software that writes it set still reads back a clean word
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         settings <= `SCS_RESET_VALUE; // [RULE_01]
      end else if (reg_write && reg_addr == `SCS_REG_OFFSET) begin
         settings <= reg_wdata & `SCS_WRITE_MASK; // [RULE_10]
      end
   end

   // a write lands whole, and nothing else may disturb the word
   write_take_a: assert property ( // [RULE_10]
      @(posedge ref_clk) disable iff (!resetn)
      reg_write && reg_addr == `SCS_REG_OFFSET |=>
      settings == ($past(reg_wdata) & `SCS_WRITE_MASK))
      else $error("register write not stored");
   write_hold_a: assert property ( // [RULE_10]
      @(posedge ref_clk) disable iff (!resetn)
      !(reg_write && reg_addr == `SCS_REG_OFFSET) |=> $stable(settings))
      else $error("register changed without a mapped write");

   // read back the whole word at the one mapped address, zero elsewhere
   always_comb begin
      if (reg_addr == `SCS_REG_OFFSET) begin
         reg_rdata = settings;
      end else begin
         reg_rdata = 16'h0000;
      end
   end

   // field split
   assign crystal_divider_sel = settings[`SCS_DIV_HI:`SCS_DIV_LO]; // [RULE_02]
   assign clock_output_source_sel = settings[`SCS_SEL_HI:`SCS_SEL_LO];
   assign osc_pll_power_on = settings[`SCS_BIT_POWER]; // [RULE_01]
   assign vendor_eval_bit = settings[`SCS_BIT_EVAL]; // [RULE_10]
   assign source_kind = scs_src_t'(clock_output_source_sel); // [RULE_08]

   // mode register output, each code is its own mode number; all sixteen
   // codes are legal, so there is no decode or clamp on this path
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         app_mode <= `SCS_MODE_RESET; // [RULE_05]
      end else begin
         app_mode <= settings[`SCS_MODE_HI:`SCS_MODE_LO]; // [RULE_11]
      end
   end

   // mode output trails the register by exactly one cycle
   mode_follow_a: assert property ( // [RULE_11]
      @(posedge ref_clk) disable iff (!resetn)
      ##1 app_mode == $past(settings[`SCS_MODE_HI:`SCS_MODE_LO]))
      else $error("mode output lags register");

   // divider decode: pairs of codes per rate, even code is 256x;
   // codes above 11 are not clamped and decode from bits 3:1 alone
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sample_rate_code <= `SCS_RATE_RESET;
         sysclk_is_384 <= 1'b0;
      end else begin
         sample_rate_code <= crystal_divider_sel[3:1]; // [RULE_04]
         sysclk_is_384 <= crystal_divider_sel[0]; // [RULE_02] [RULE_04]
      end
   end

   // rate pair and 256/384 flag both come from the divider field
   div_decode_a: assert property ( // [RULE_02]
      @(posedge ref_clk) disable iff (!resetn)
      ##1 sysclk_is_384 == $past(crystal_divider_sel[0]))
      else $error("256/384 decode wrong");
   rate_decode_a: assert property ( // [RULE_04]
      @(posedge ref_clk) disable iff (!resetn)
      ##1 sample_rate_code == $past(crystal_divider_sel[3:1]))
      else $error("sampling rate decode wrong");

   // crystal output ratio follows the divider, pll ratio follows select;
   // both crystal codes behave alike, the spare code has no meaning here
   always_comb begin
      from_xtal = 1'b0;
      ratio_384 = 1'b0;
      case (source_kind)
         SCS_PLL_256: begin
            ratio_384 = 1'b0; // [RULE_09]
         end
         SCS_PLL_384: begin
            ratio_384 = 1'b1; // [RULE_09]
         end
         default: begin
            from_xtal = 1'b1; // [RULE_08]
            ratio_384 = crystal_divider_sel[0]; // [RULE_03]
         end
      endcase
      src_tick = from_xtal ? xtal_tick : pll_ref_tick;
   end

   // clock enables stop entirely while powered down, so nothing
   // downstream sees a stray edge from a dead oscillator
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         clock_out_en <= 1'b0;
         output_bit_clock_en <= 1'b0;
         input_bit_clock_en <= 1'b0;
      end else begin
         clock_out_en <= osc_pll_power_on && src_tick; // [RULE_12]
         output_bit_clock_en <= osc_pll_power_on && src_tick; // [RULE_12]
         input_bit_clock_en <= osc_pll_power_on && src_tick; // [RULE_12]
      end
   end

   // ratio sits in a flop so a select change takes effect on a clean
   // cycle boundary rather than part way through one
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bit_clock_ratio <= `SCS_BCK_256;
      end else begin
         bit_clock_ratio <= ratio_384 ? `SCS_BCK_384 // [RULE_03]
                                      : `SCS_BCK_256; // [RULE_09]
      end
   end

   // power gating of every derived enable
   power_off_stop_a: assert property ( // [RULE_12]
      @(posedge ref_clk) disable iff (!resetn)
      !osc_pll_power_on |=> !clock_out_en && !output_bit_clock_en
      && !input_bit_clock_en)
      else $error("clock enable toggled while powered down");
   power_on_run_a: assert property ( // [RULE_01]
      @(posedge ref_clk) disable iff (!resetn)
      osc_pll_power_on && clock_output_source_sel[1] && xtal_tick
      |=> output_bit_clock_en && input_bit_clock_en)
      else $error("bit clock enables stuck while powered");

   // source selection: crystal for the upper codes, pll for the lower
   src_xtal_a: assert property ( // [RULE_08]
      @(posedge ref_clk) disable iff (!resetn)
      osc_pll_power_on && clock_output_source_sel[1] && xtal_tick
      |=> clock_out_en)
      else $error("crystal source not used");
   src_pll_a: assert property ( // [RULE_08]
      @(posedge ref_clk) disable iff (!resetn)
      !clock_output_source_sel[1] |=>
      clock_out_en == ($past(osc_pll_power_on) && $past(pll_ref_tick)))
      else $error("pll source not used");

   // bit clock ratio per source
   ratio_xtal_a: assert property ( // [RULE_03]
      @(posedge ref_clk) disable iff (!resetn)
      clock_output_source_sel[1] |=> bit_clock_ratio ==
      ($past(crystal_divider_sel[0]) ? `SCS_BCK_384 : `SCS_BCK_256))
      else $error("crystal bit clock ratio wrong");
   ratio_pll_a: assert property ( // [RULE_09]
      @(posedge ref_clk) disable iff (!resetn)
      !clock_output_source_sel[1] |=> bit_clock_ratio ==
      ($past(clock_output_source_sel[0]) ? `SCS_BCK_384 : `SCS_BCK_256))
      else $error("pll bit clock ratio wrong");

   // word select comes from a pin, so synchronise it first
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ws_s1 <= 1'b0;
         ws_s2 <= 1'b0;
      end else begin
         ws_s1 <= word_select_pin;
         ws_s2 <= ws_s1;
      end
   end

   assign rate.detector_on = settings[`SCS_BIT_DET_EN]; // [RULE_06]
   assign rate.limit_cycles = settings[`SCS_BIT_DET_LIM] ?
      `SCS_LIMIT_HIGH : `SCS_LIMIT_LOW; // [RULE_07]
   assign frame_rate_low = rate.frame_rate_low;

   // the detector only ever sees the synchronised copy of the pin
   scs_frame_detector scs_frame_detector_inst (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .word_select (ws_s2),
      .rate        (rate)
   );
endmodule

// ---- scs_system_clock_bench.sv ----
// Purpose: self-checking bench for the system clock settings register
// Assumes: writes taken on the rising edge, inputs driven on falling edge
// Notes:   detector waits sit just inside and outside the cycle limits
`timescale 1ns/1ps
module scs_system_clock_bench;
   logic        ref_clk = 0;
   logic        resetn = 0;
   logic        reg_write = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        pll_ref_tick = 0;
   logic        xtal_tick = 0;
   logic        ws = 0;
   wire  [15:0] rdata;
   wire  [3:0]  mode;
   wire  [2:0]  rate;
   wire  [6:0]  ratio;
   wire         is384, pwr, ck_en, ob_en, ib_en, low, evb;
   int          mismatches = 0;
   int          compares = 0;

   scs_system_clock scs_system_clock_inst (.ref_clk(ref_clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_rdata(rdata),
      .pll_ref_tick(pll_ref_tick), .xtal_tick(xtal_tick),
      .word_select_pin(ws), .app_mode(mode), .sample_rate_code(rate),
      .sysclk_is_384(is384), .osc_pll_power_on(pwr),
      .clock_out_en(ck_en), .output_bit_clock_en(ob_en),
      .input_bit_clock_en(ib_en), .bit_clock_ratio(ratio),
      .frame_rate_low(low), .vendor_eval_bit(evb));

   // 50 ns period
   always #25 ref_clk = ~ref_clk;

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // one write, then wait until derived outputs have settled
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1;
      @(negedge ref_clk);
      reg_write = 0;
      reg_addr = 8'h00;
      @(negedge ref_clk);
   endtask

   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic t_reset;
      chk("reset word", 16'h282a, rdata);
      chk("reset mode", 16'h0002, mode);
      chk("reset rate", 16'h0004, rate);
      chk("reset is384", 16'h0000, is384);
      chk("reset power", 16'h0001, pwr);
      chk("reset detector", 16'h0008, rdata & 16'h0008);
      chk("reset ratio", 16'h0040, ratio);
      chk("reset eval bit", 16'h0000, evb);
      $display("reset test done");
   endtask

   task automatic t_mode;
      for (int m = 0; m < 16; m++) begin
         wr(8'h00, {8'h28, 4'(m), 4'h2});
         chk("mode", 16'(m), mode);
      end
      $display("mode test done");
   endtask

   // crystal source: ratio follows divider parity, then both pll select ratios
   task automatic t_div;
      logic [4:0] d;
      for (int i = 0; i < 12; i++) begin
         d = 5'(i);
         wr(8'h00, {3'b001, d, 8'h2a});
         chk("rate", 16'(d[3:1]), rate);
         chk("is384", 16'(d[0]), is384);
         chk("xtal ratio", d[0] ? 16'd48 : 16'd64, ratio);
      end
      wr(8'h00, 16'h2820);
      chk("pll256 ratio", 16'd64, ratio);
      wr(8'h00, 16'h2821);
      chk("pll384 ratio", 16'd48, ratio);
      $display("divider test done");
   endtask

   // bit 14 never stored, other addresses ignored and read zero;
   // bit 15 stays clear as the host is expected to keep it
   task automatic t_refuse;
      wr(8'h00, 16'h7fff);
      chk("bit14", 16'h3fff, rdata);
      chk("eval bit", 16'h0000, evb);
      wr(8'h01, 16'h0000);
      chk("unmapped write", 16'h3fff, rdata);
      reg_addr = 8'h01;
      @(posedge ref_clk);
      chk("unmapped read", 16'h0000, rdata);
      @(negedge ref_clk);
      reg_addr = 8'h00;
      $display("refuse test done");
   endtask

   // power gating, then the pll source must ignore the crystal tick
   task automatic t_power;
      pll_ref_tick = 1;
      xtal_tick = 1;
      wr(8'h00, 16'h0822);
      chk("off enables", 16'h0000, {ck_en, ob_en, ib_en, pwr});
      wr(8'h00, 16'h2822);
      chk("on enables", 16'h000f, {ck_en, ob_en, ib_en, pwr});
      pll_ref_tick = 0;
      wr(8'h00, 16'h2820);
      chk("pll idle", 16'h0001, {ck_en, ob_en, ib_en, pwr});
      pll_ref_tick = 1;
      xtal_tick = 0;
      repeat (2) @(negedge ref_clk);
      chk("pll enables", 16'h000f, {ck_en, ob_en, ib_en, pwr});
      pll_ref_tick = 0;
      $display("power test done");
   endtask

   task automatic ws_edge;
      ws = 0;
      repeat (2) @(negedge ref_clk);
      ws = 1;
      repeat (2) @(negedge ref_clk);
   endtask

   task automatic t_detect;
      wr(8'h00, 16'h282e);
      ws_edge;
      repeat (2000) @(negedge ref_clk);
      chk("inside 2047", 16'h0000, low);
      repeat (120) @(negedge ref_clk);
      chk("past 2047", 16'h0001, low);
      wr(8'h00, 16'h282a);
      ws_edge;
      repeat (6) @(negedge ref_clk);
      chk("edge clears", 16'h0000, low);
      repeat (4000) @(negedge ref_clk);
      chk("inside 4095", 16'h0000, low);
      repeat (150) @(negedge ref_clk);
      chk("past 4095", 16'h0001, low);
      wr(8'h00, 16'h2822);
      chk("disabled", 16'h0000, low);
      $display("detector test done");
   endtask

   // watchdog well beyond the roughly 6400 cycles the tests need
   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      $display("watchdog expired");
      test_done;
   end

   initial begin
      repeat (6) @(negedge ref_clk);
      resetn = 1;
      @(negedge ref_clk);
      t_reset;
      t_mode;
      t_div;
      t_refuse;
      t_power;
      t_detect;
      test_done;
   end
endmodule
